// File: design/udc_counter.sv
// Dual-clock 4-bit up/down counter with preset, clear, carry and underflow.
// Assumes all inputs are synchronous to REF_CLK; count clocks are sampled levels.

// Operation
// - 4-bit count, all bits update together
// - Direction set by which clock rises
// - Low preset strobe loads data inputs
// - High clear forces count to zero
// - Clear beats preset, data and count
// - Underflow low at zero with decrement low
// - Carry low at fifteen with increment low
// - Count wraps modulo sixteen both ways
module udc_counter
    import udc_pkg::*;
(
    input  wire logic             REF_CLK,
    input  wire logic             RST_N,
    input  wire logic             INCREMENT_CLOCK,
    input  wire logic             DECREMENT_CLOCK,
    input  wire logic             COUNTER_CLEAR,
    input  wire logic             PRESET_STROBE_N,
    input  wire logic [UDC_W-1:0] DATA_IN,
    output logic      [UDC_W-1:0] COUNT_OUT,
    output logic                  CARRY_OUT_N,
    output logic                  UNDERFLOW_OUT_N
);

    // ----------------------------------------------------------------
    // Edge detection
    // ----------------------------------------------------------------
    // History resets high, so a clock held high at release is no edge
    logic inc_rise;
    logic dec_rise;

    udc_edge_detect #(.IDLE_LEVEL(UDC_CLK_IDLE)) u_inc_edge (
        .ref_clk  (REF_CLK),
        .rst_n    (RST_N),
        .level_in (INCREMENT_CLOCK),
        .rise     (inc_rise)
    );

    udc_edge_detect #(.IDLE_LEVEL(UDC_CLK_IDLE)) u_dec_edge (
        .ref_clk  (REF_CLK),
        .rst_n    (RST_N),
        .level_in (DECREMENT_CLOCK),
        .rise     (dec_rise)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Clear and preset act at the edge so every output stays registered
    udc_state_t st_reg;
    udc_state_t st_next;
    udc_op_t    op;

    always_comb begin
        op = UDC_OP_HOLD;
        if (COUNTER_CLEAR || !PRESET_STROBE_N) begin
            op = UDC_OP_FORCE;
        end else if (inc_rise && DECREMENT_CLOCK) begin
            op = UDC_OP_UP;
        end else if (dec_rise && INCREMENT_CLOCK) begin
            op = UDC_OP_DOWN;
        end
    end

    always_comb begin
        st_next = st_reg;
        case (op)
            UDC_OP_FORCE: begin
                // Clear first so a held preset never leaks through
                if (COUNTER_CLEAR) begin
                    st_next.count = UDC_ZERO;
                end else begin
                    st_next.count = DATA_IN;
                end
            end
            UDC_OP_UP: begin
                st_next.count = st_reg.count + UDC_ONE;
            end
            UDC_OP_DOWN: begin
                st_next.count = st_reg.count - UDC_ONE;
            end
            default: begin
                st_next.count = st_reg.count;
            end
        endcase
        // Flags registered from next count: one cycle behind the clock input
        st_next.carry_out_n     = ~((st_next.count == UDC_MAX) && !INCREMENT_CLOCK);
        st_next.underflow_out_n = ~((st_next.count == UDC_ZERO) && !DECREMENT_CLOCK);
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            st_reg.count           <= UDC_ZERO;
            st_reg.carry_out_n     <= UDC_FLAG_IDLE;
            st_reg.underflow_out_n <= UDC_FLAG_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign COUNT_OUT       = st_reg.count;
    assign CARRY_OUT_N     = st_reg.carry_out_n;
    assign UNDERFLOW_OUT_N = st_reg.underflow_out_n;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    // Count events as the logic should see them, from pins and rises
    logic up_ev;
    logic dn_ev;
    assign up_ev = !COUNTER_CLEAR && PRESET_STROBE_N && inc_rise && DECREMENT_CLOCK;
    assign dn_ev = !COUNTER_CLEAR && PRESET_STROBE_N && dec_rise && INCREMENT_CLOCK;

    property p_clear;
        COUNTER_CLEAR |=> (COUNT_OUT == UDC_ZERO);
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero count");

    property p_clear_over_preset;
        (COUNTER_CLEAR && !PRESET_STROBE_N) ##1 COUNTER_CLEAR |=> (COUNT_OUT == UDC_ZERO);
    endproperty
    a_clear_over_preset: assert property (p_clear_over_preset)
        else $error("preset beat clear");

    property p_preset;
        (!COUNTER_CLEAR && !PRESET_STROBE_N) |=> (COUNT_OUT == $past(DATA_IN));
    endproperty
    a_preset: assert property (p_preset) else $error("preset value wrong");

    property p_up;
        up_ev |=> (COUNT_OUT == $past(COUNT_OUT) + UDC_ONE);
    endproperty
    a_up: assert property (p_up) else $error("up count wrong");

    property p_down;
        dn_ev |=> (COUNT_OUT == $past(COUNT_OUT) - UDC_ONE);
    endproperty
    a_down: assert property (p_down) else $error("down count wrong");

    property p_wrap;
        (up_ev && COUNT_OUT == UDC_MAX) or (dn_ev && COUNT_OUT == UDC_ZERO)
            |=> (COUNT_OUT == ($past(up_ev) ? UDC_ZERO : UDC_MAX));
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap wrong");

    property p_hold;
        (!COUNTER_CLEAR && PRESET_STROBE_N && !up_ev && !dn_ev) |=> $stable(COUNT_OUT);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved without edge");

    property p_ignore;
        (COUNTER_CLEAR && (inc_rise || dec_rise)) |=> (COUNT_OUT == UDC_ZERO);
    endproperty
    a_ignore: assert property (p_ignore) else $error("edge counted during clear");

    property p_ignore_preset;
        (!COUNTER_CLEAR && !PRESET_STROBE_N && (inc_rise || dec_rise))
            |=> (COUNT_OUT == $past(DATA_IN));
    endproperty
    a_ignore_preset: assert property (p_ignore_preset)
        else $error("edge counted during preset");

    property p_step;
        (!COUNTER_CLEAR && PRESET_STROBE_N) |=> ((COUNT_OUT == $past(COUNT_OUT))
            || (COUNT_OUT == $past(COUNT_OUT) + UDC_ONE)
            || (COUNT_OUT == $past(COUNT_OUT) - UDC_ONE));
    endproperty
    a_step: assert property (p_step) else $error("count jumped more than one");

    property p_carry;
        1'b1 |=> (CARRY_OUT_N == !((COUNT_OUT == UDC_MAX) && !$past(INCREMENT_CLOCK)));
    endproperty
    a_carry: assert property (p_carry) else $error("carry flag wrong");

    property p_underflow;
        1'b1 |=> (UNDERFLOW_OUT_N == !((COUNT_OUT == UDC_ZERO) && !$past(DECREMENT_CLOCK)));
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow flag wrong");

    // ----------------------------------------------------------------
    // Flag assertions
    // ----------------------------------------------------------------
    // Flags lag the clock pins by one cycle: the price of registered outputs
    property p_carry_low;
        (!COUNTER_CLEAR && PRESET_STROBE_N && COUNT_OUT == UDC_MAX && !INCREMENT_CLOCK)
            |=> !CARRY_OUT_N;
    endproperty
    a_carry_low: assert property (p_carry_low) else $error("carry not asserted");

    property p_underflow_low;
        (!COUNTER_CLEAR && PRESET_STROBE_N && COUNT_OUT == UDC_ZERO && !DECREMENT_CLOCK)
            |=> !UNDERFLOW_OUT_N;
    endproperty
    a_underflow_low: assert property (p_underflow_low) else $error("underflow not asserted");

    property p_clear_carry;
        COUNTER_CLEAR |=> CARRY_OUT_N;
    endproperty
    a_clear_carry: assert property (p_clear_carry) else $error("carry low after clear");

    property p_clear_underflow;
        COUNTER_CLEAR |=> (UNDERFLOW_OUT_N == $past(DECREMENT_CLOCK));
    endproperty
    a_clear_underflow: assert property (p_clear_underflow)
        else $error("underflow wrong after clear");

    c_up_wrap:   cover property (up_ev && COUNT_OUT == UDC_MAX);
    c_down_wrap: cover property (dn_ev && COUNT_OUT == UDC_ZERO);
    c_preset:    cover property (!COUNTER_CLEAR && !PRESET_STROBE_N);
    c_both:      cover property (COUNTER_CLEAR && !PRESET_STROBE_N);
    c_carry_low: cover property (!CARRY_OUT_N);

endmodule

// File: include/udc_pkg.sv
// Package for the dual-clock up/down counter: widths, constants, state types.
// Assumes a single system clock samples all counter inputs.
package udc_pkg;

    // ----------------------------------------------------------------
    // Count field
    // ----------------------------------------------------------------
    localparam int          UDC_W        = 4;
    localparam logic [3:0]  UDC_ZERO     = 4'h0;
    localparam logic [3:0]  UDC_ONE      = 4'h1;
    localparam logic [3:0]  UDC_MAX      = 4'hF;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic        UDC_FLAG_IDLE  = 1'h1;
    localparam logic        UDC_CLK_IDLE   = 1'h1;

    // ----------------------------------------------------------------
    // State types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [UDC_W-1:0] count;
        logic             carry_out_n;
        logic             underflow_out_n;
    } udc_state_t;

    typedef struct packed {
        logic prev;
    } udc_edge_state_t;

    typedef enum logic [1:0] {
        UDC_OP_HOLD   = 2'b00,
        UDC_OP_UP     = 2'b01,
        UDC_OP_DOWN   = 2'b10,
        UDC_OP_FORCE  = 2'b11
    } udc_op_t;

endpackage

// File: design/udc_edge_detect.sv
// Rising-edge detector for one count clock input.
// Assumes the input is synchronous to REF_CLK.
module udc_edge_detect
    import udc_pkg::*;
#(
    parameter logic IDLE_LEVEL = UDC_CLK_IDLE
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic level_in,
    output logic      rise
);

    udc_edge_state_t st_reg;
    udc_edge_state_t st_next;

    always_comb begin
        st_next.prev = level_in;
    end

    // Reset to idle high so a high input at release is no edge
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_reg.prev <= IDLE_LEVEL;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rise = level_in & ~st_reg.prev;

endmodule

// File: bench/udc_drv_model.sv
// Model of the driving logic for the two count clocks.
// Assumes commands change just after rising edges of the system clock.
module udc_drv_model
    import udc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic up_req,
    input  wire logic dn_req,
    output logic      inc_clk = UDC_CLK_IDLE,
    output logic      dec_clk = UDC_CLK_IDLE
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Clocks idle high; a command pulls one low for a cycle
    // ------------------------------------------------------------
    // Registered so both clocks move just after an edge; a clock only falls
    // while the other is high, and a clash of requests is dropped
    always @(posedge ref_clk) begin
        inc_clk <= !(up_req && !dn_req && dec_clk);
        dec_clk <= !(dn_req && !up_req && inc_clk);
    end
endmodule

// File: bench/tb_udc_counter.sv
// Self-checking bench for the dual-clock up/down counter.
// Assumes the design samples every input on the rising system clock edge.
module tb_udc_counter
    import udc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [UDC_W-1:0] cnt;
        logic             co_n;
        logic             uo_n;
        logic [UDC_W-1:0] cnt2;
        logic             co2_n;
        logic             uo2_n;
    } udc_note_t;

    logic             ref_clk = 1'b0;
    logic             rst_n   = 1'b0;
    logic             up_req  = 1'b0;
    logic             dn_req  = 1'b0;
    logic             clr     = 1'b0;
    logic             ld_n    = 1'b1;
    logic [UDC_W-1:0] din     = UDC_ZERO;
    logic [UDC_W-1:0] cnt;
    logic             inc_clk;
    logic             dec_clk;
    logic             co_n;
    logic             uo_n;
    logic [UDC_W-1:0] cnt2;
    logic             co2_n;
    logic             uo2_n;
    logic [UDC_W-1:0] m;
    logic [UDC_W-1:0] m2;
    logic             pi2;
    logic             pd2;
    logic             pi;
    logic             pd;
    logic [31:0]      r;
    udc_note_t        exp_n;
    udc_note_t        got;
    udc_note_t        q[$];
    int               error_cnt = 0;
    int               n_tests   = 0;
    integer           seed      = 32'hc234;

    always #12.5 ref_clk = ~ref_clk;

    udc_drv_model udc_drv_model_i (.ref_clk(ref_clk), .up_req(up_req), .dn_req(dn_req),
        .inc_clk(inc_clk), .dec_clk(dec_clk));

    udc_counter udc_counter_i (.REF_CLK(ref_clk), .RST_N(rst_n), .INCREMENT_CLOCK(inc_clk),
        .DECREMENT_CLOCK(dec_clk), .COUNTER_CLEAR(clr), .PRESET_STROBE_N(ld_n), .DATA_IN(din),
        .COUNT_OUT(cnt), .CARRY_OUT_N(co_n), .UNDERFLOW_OUT_N(uo_n));

    // Second stage chained straight off the first stage's flags
    udc_counter udc_counter_hi_i (.REF_CLK(ref_clk), .RST_N(rst_n), .INCREMENT_CLOCK(co_n),
        .DECREMENT_CLOCK(uo_n), .COUNTER_CLEAR(clr), .PRESET_STROBE_N(ld_n), .DATA_IN(din),
        .COUNT_OUT(cnt2), .CARRY_OUT_N(co2_n), .UNDERFLOW_OUT_N(uo2_n));

    // ------------------------------------------------------------
    // Expectation notes, one per edge, from pre-edge input values
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            m = UDC_ZERO;
            m2 = UDC_ZERO;
            exp_n = {UDC_ZERO, 2'b11, UDC_ZERO, 2'b11};
        end else begin
            if (clr) m = UDC_ZERO;
            else if (!ld_n) m = din;
            else if (inc_clk && !pi && dec_clk) m = m + UDC_ONE;
            else if (dec_clk && !pd && inc_clk) m = m - UDC_ONE;
            // Stage two counts the first stage's carry and underflow pulses
            if (clr) m2 = UDC_ZERO;
            else if (!ld_n) m2 = din;
            else if (co_n && !pi2 && uo_n) m2 = m2 + UDC_ONE;
            else if (uo_n && !pd2 && co_n) m2 = m2 - UDC_ONE;
            exp_n = {m, !(m == UDC_MAX && !inc_clk), !(m == UDC_ZERO && !dec_clk),
                     m2, !(m2 == UDC_MAX && !co_n), !(m2 == UDC_ZERO && !uo_n)};
        end
        // History starts high, so clocks high at release never count
        pi = rst_n ? inc_clk : 1'b1;
        pd = rst_n ? dec_clk : 1'b1;
        pi2 = rst_n ? co_n : 1'b1;
        pd2 = rst_n ? uo_n : 1'b1;
        q.push_back(exp_n);
    end

    task automatic report(input string s);
        error_cnt++;
        $display("ERROR %0t %s mismatch", $time, s);
    endtask

    // Compared mid-cycle, well clear of the launching edge
    always @(negedge ref_clk) begin
        if (q.size() > 0) begin
            got = q.pop_front();
            n_tests += 6;
            if (cnt2 !== got.cnt2) report("stage two count");
            if (co2_n !== got.co2_n) report("stage two carry");
            if (uo2_n !== got.uo2_n) report("stage two underflow");
            if (cnt !== got.cnt) report("count");
            if (co_n !== got.co_n) report("carry");
            if (uo_n !== got.uo_n) report("underflow");
        end
    end

    task automatic op(input logic u, input logic d, input logic c, input logic l,
                      input logic [UDC_W-1:0] data, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            up_req <= u;
            dn_req <= d;
            clr    <= c;
            ld_n   <= l;
            din    <= data;
        end
    endtask

    task automatic finish_test;
        $display("Checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        op(1'b0, 1'b0, 1'b1, 1'b1, 4'h0, 2);
        op(1'b0, 1'b0, 1'b0, 1'b0, 4'hD, 2);
        for (int i = 0; i < 10; i++) begin
            op(i < 5, i >= 5, 1'b0, 1'b1, 4'h0, 1);
            op(1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 2);
        end
        $display("Test wrap count done");
        op(1'b0, 1'b0, 1'b1, 1'b0, 4'h7, 2);
        op(1'b1, 1'b0, 1'b1, 1'b1, 4'h0, 1);
        op(1'b0, 1'b0, 1'b1, 1'b1, 4'h0, 2);
        op(1'b0, 1'b1, 1'b0, 1'b0, 4'h5, 1);
        op(1'b0, 1'b0, 1'b0, 1'b0, 4'h5, 2);
        op(1'b1, 1'b1, 1'b0, 1'b1, 4'h0, 1);
        op(1'b0, 1'b1, 1'b0, 1'b1, 4'h0, 2);
        op(1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 2);
        $display("Test overrides done");
        repeat (400) begin
            r = $random(seed);
            op(r[0], r[1] & r[2], r[7:4] == 4'h0, r[11:8] != 4'h0, r[15:12], 1);
        end
        $display("Test random done");
        @(posedge ref_clk);
        rst_n <= 1'b0;
        op(1'b1, 1'b0, 1'b0, 1'b1, 4'h0, 2);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        op(1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 4);
        $display("Test mid reset done");
        @(negedge ref_clk);
        finish_test;
    end
endmodule
